/* File: src/snf_cfg.svh */
// Constants of the serial NAND front end: register offsets, field
// positions, reset values and address limits.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef SNF_CFG_SVH
`define SNF_CFG_SVH

// ****************************************
// Register offsets (4-bit address)
// ****************************************
`define SNF_OFS_FEAT 4'h0
`define SNF_OFS_CTRL 4'h1
`define SNF_OFS_TX 4'h2
`define SNF_OFS_RX 4'h3
`define SNF_OFS_STAT 4'h4
`define SNF_OFS_CMD 4'h5
`define SNF_OFS_COL_LO 4'h6
`define SNF_OFS_COL_HI 4'h7
`define SNF_OFS_ROW0 4'h8
`define SNF_OFS_ROW1 4'h9
`define SNF_OFS_ROW2 4'hA
`define SNF_OFS_MAP 4'hB
`define SNF_OFS_PAGE 4'hC
`define SNF_OFS_BLK_LO 4'hD
`define SNF_OFS_BLK_HI 4'hE

// ****************************************
// Feature register fields and reset
// ****************************************
`define SNF_FB_QE 0
`define SNF_FB_LOCKEN 1
`define SNF_FB_ECC 2
`define SNF_FB_PROT_LO 3
`define SNF_FB_PROT_HI 7
`define SNF_FEAT_RST 8'h04

// ****************************************
// Status fields
// ****************************************
`define SNF_SB_SEL 0
`define SNF_SB_PAUSE 1
`define SNF_SB_CMD 2
`define SNF_SB_RXRDY 3
`define SNF_SB_REJ 4
`define SNF_SB_TXLD 5

// ****************************************
// Pins, lanes and address limits
// ****************************************
`define SNF_PIN_RST 6'h3E
`define SNF_COL_LAST_ECC_OFF 12'h87F
`define SNF_COL_LAST_ECC_ON 12'h83F
`define SNF_SPARE_BASE 12'h800
`define SNF_SPARE_PROG_LAST 12'h83F

`endif

/* File: src/snf_pkg.sv */
// Types of the serial NAND front end.
// Assumes nothing beyond a SystemVerilog compiler.
package snf_pkg;

    // Interface state
    typedef enum logic [1:0] {
        SNF_IDLE = 2'b00,
        SNF_CMD = 2'b01,
        SNF_DATA = 2'b10,
        SNF_REJECT = 2'b11
    } snf_state_t;

    // Transfer width after the command byte
    typedef enum logic [1:0] {
        SNF_X1 = 2'b00,
        SNF_X2 = 2'b01,
        SNF_X4 = 2'b10,
        SNF_X4DTR = 2'b11
    } snf_lanes_t;

endpackage

/* File: src/snf_pin_sync.sv */
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes pins are asynchronous to sys_clk; bit order is the caller's.
`timescale 1ns/1ps
`include "snf_cfg.svh"

module snf_pin_sync (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [5:0] pin,
    output logic [5:0] level,
    output logic [5:0] rise,
    output logic [5:0] fall
);

    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] next_level;

    // Level follows only when stages two and three agree
    assign next_level = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & level);

    // Synchroniser chain
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s1 <= `SNF_PIN_RST;
            s2 <= `SNF_PIN_RST;
            s3 <= `SNF_PIN_RST;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Filtered level and one-cycle edge pulses
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            level <= `SNF_PIN_RST;
            rise <= 6'h00;
            fall <= 6'h00;
        end else begin
            level <= next_level;
            rise <= next_level & ~level;
            fall <= ~next_level & level;
        end
    end

endmodule

/* File: src/snf_addr_map.sv */
// Column and row address decode onto page, block and spare area.
// Assumes registered inputs; outputs are combinational.
`timescale 1ns/1ps
`include "snf_cfg.svh"

module snf_addr_map (
    input wire logic [11:0] column_offset,
    input wire logic [17:0] row_index,
    input wire logic ecc_on,
    output logic col_in_bounds,
    output logic read_ok,
    output logic prog_ok,
    output logic in_spare,
    output logic [5:0] page,
    output logic [11:0] block
);

    assign page = row_index[5:0];
    assign block = row_index[17:6];

    assign col_in_bounds = ecc_on ? (column_offset <= `SNF_COL_LAST_ECC_ON)
                                  : (column_offset <= `SNF_COL_LAST_ECC_OFF);
    assign in_spare = (column_offset >= `SNF_SPARE_BASE) &&
                      (column_offset <= `SNF_COL_LAST_ECC_OFF);

    assign read_ok = column_offset <= `SNF_COL_LAST_ECC_OFF;

    assign prog_ok = ecc_on ? (column_offset <= `SNF_SPARE_PROG_LAST)
                            : (column_offset <= `SNF_COL_LAST_ECC_OFF);

    // beyond the last byte is refused
    col_bound_a: assert final (column_offset <= `SNF_COL_LAST_ECC_OFF || !col_in_bounds)
        else $error("column beyond last byte marked valid");

endmodule

/* File: src/snf_front.sv */
// Serial interface front end of a NAND flash: command byte capture,
// one/two/four-lane and four-lane double-rate shifting, pause, lock.
// Assumes pins asynchronous to sys_clk and sclk well below sys_clk / 6.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "snf_cfg.svh"

// Behaviour
// - Only modes 0 and 3 supported
// - Sample on rise, drive on fall
// - Two-lane commands use lanes zero, one
// - Four-lane commands use all four lanes
// - Double-rate read moves data both edges
// - Four-lane commands need four_lane_enable set
// - Pause only when four_lane_enable clear
// - Pause stops serial traffic only
// - Pause enters and leaves with clock low
// - Paused: outputs released, inputs ignored
// - Deselect during pause resets interface
// - Lock blocks protect bit changes
// - Lock pin works only lanes mode off
// - Column offset bounded by ECC setting
// - Row splits into page and block
// - ECC on: first 64 spare programmable
// - ECC off: whole spare programmable
module snf_front (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic serial_input_lane_zero_i,
    output logic serial_input_lane_zero_o,
    output logic serial_input_lane_zero_oe,
    input wire logic serial_out_lane_one_i,
    output logic serial_out_lane_one_o,
    output logic serial_out_lane_one_oe,
    input wire logic lock_pin_n_i,
    output logic lock_pin_n_o,
    output logic lock_pin_n_oe,
    input wire logic pause_n_i,
    output logic pause_n_o,
    output logic pause_n_oe
);

    // ****************************************
    // Functions
    // ****************************************

    // Bits moved per active edge
    function automatic logic [2:0] lane_bits(input snf_pkg::snf_lanes_t m);
        unique case (m)
            snf_pkg::SNF_X1: lane_bits = 3'h1;
            snf_pkg::SNF_X2: lane_bits = 3'h2;
            snf_pkg::SNF_X4: lane_bits = 3'h4;
            snf_pkg::SNF_X4DTR: lane_bits = 3'h4;
        endcase
    endfunction

    // Shift the sampled lanes into a byte
    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] ln,
                                            input snf_pkg::snf_lanes_t m);
        unique case (m)
            snf_pkg::SNF_X1: shift_in = {sh[6:0], ln[0]};
            snf_pkg::SNF_X2: shift_in = {sh[5:0], ln[1], ln[0]};
            snf_pkg::SNF_X4: shift_in = {sh[3:0], ln};
            snf_pkg::SNF_X4DTR: shift_in = {sh[3:0], ln};
        endcase
    endfunction

    // Opcode to transfer width
    function automatic snf_pkg::snf_lanes_t decode(input logic [7:0] op);
        unique case (op)
            8'h3B, 8'hBB: decode = snf_pkg::SNF_X2;
            8'h6B, 8'hEB, 8'h32, 8'h34, 8'hC4: decode = snf_pkg::SNF_X4;
            8'hEE: decode = snf_pkg::SNF_X4DTR;
            default: decode = snf_pkg::SNF_X1;
        endcase
    endfunction

    // ****************************************
    // Pin synchronisation
    // ****************************************

    logic [5:0] lvl;
    logic [5:0] rise;
    logic [5:0] fall;

    snf_pin_sync u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .pin({pause_n_i, lock_pin_n_i, serial_out_lane_one_i,
              serial_input_lane_zero_i, chip_select_n, sclk}),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    logic sclk_lvl;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_lvl;
    logic cs_rise;
    logic cs_fall;
    logic [3:0] lanes;
    logic lock_lvl;
    logic pause_lvl;

    assign sclk_lvl = lvl[0];
    assign sclk_rise = rise[0];
    assign sclk_fall = fall[0];
    assign cs_lvl = lvl[1];
    assign cs_rise = rise[1];
    assign cs_fall = fall[1];
    assign lanes = lvl[5:2];
    assign lock_lvl = lvl[4];
    assign pause_lvl = lvl[5];

    // ****************************************
    // Registers
    // ****************************************

    logic [7:0] feat;
    logic drive_out;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [7:0] cmd;
    logic [11:0] column_offset;
    logic [17:0] row_index;
    logic st_cmd;
    logic st_rxrdy;
    logic st_rej;
    logic st_txld;
    logic four_lane_enable;
    logic protect_bits_lock_enable;
    logic lock_act;
    logic wr_feat;
    logic clr_stat;

    assign four_lane_enable = feat[`SNF_FB_QE];
    assign protect_bits_lock_enable = feat[`SNF_FB_LOCKEN];
    assign wr_feat = reg_we && reg_addr == `SNF_OFS_FEAT;
    assign clr_stat = reg_we && reg_addr == `SNF_OFS_STAT;

    // lock pin only without four lanes
    assign lock_act = protect_bits_lock_enable && !lock_lvl && !four_lane_enable;

    // Feature register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            feat <= `SNF_FEAT_RST;
        end else if (wr_feat) begin
            feat[`SNF_FB_ECC:`SNF_FB_QE] <= reg_wdata[`SNF_FB_ECC:`SNF_FB_QE];
            if (!lock_act) begin
                feat[`SNF_FB_PROT_HI:`SNF_FB_PROT_LO] <=
                    reg_wdata[`SNF_FB_PROT_HI:`SNF_FB_PROT_LO];
            end
        end
    end

    // Control, transmit byte and address registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            drive_out <= 1'b0;
            tx_data <= 8'h00;
            column_offset <= 12'h000;
            row_index <= 18'h00000;
        end else if (reg_we) begin
            unique case (reg_addr)
                `SNF_OFS_CTRL: drive_out <= reg_wdata[0];
                `SNF_OFS_TX: tx_data <= reg_wdata;
                `SNF_OFS_COL_LO: column_offset[7:0] <= reg_wdata;
                `SNF_OFS_COL_HI: column_offset[11:8] <= reg_wdata[3:0];
                `SNF_OFS_ROW0: row_index[7:0] <= reg_wdata;
                `SNF_OFS_ROW1: row_index[15:8] <= reg_wdata;
                `SNF_OFS_ROW2: row_index[17:16] <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Address map
    // ****************************************

    logic col_in_bounds;
    logic read_ok;
    logic prog_ok;
    logic in_spare;
    logic [5:0] page;
    logic [11:0] block;

    snf_addr_map u_map (
        .column_offset(column_offset),
        .row_index(row_index),
        .ecc_on(feat[`SNF_FB_ECC]),
        .col_in_bounds(col_in_bounds),
        .read_ok(read_ok),
        .prog_ok(prog_ok),
        .in_spare(in_spare),
        .page(page),
        .block(block)
    );

    // ****************************************
    // Pause
    // ****************************************

    logic paused;
    logic selected;
    logic act;

    assign selected = !cs_lvl;

    // enter and leave with clock low
    always_ff @(posedge sys_clk) begin
        if (srst || cs_rise || four_lane_enable) begin
            paused <= 1'b0;
        end else if (selected && !sclk_lvl) begin
            if (!paused && !pause_lvl) begin
                paused <= 1'b1;
            end else if (paused && pause_lvl) begin
                paused <= 1'b0;
            end
        end
    end

    // pause gates only the serial edges and the pin drivers
    assign act = selected && !paused;

    // ****************************************
    // Shifter
    // ****************************************

    snf_pkg::snf_state_t state;
    snf_pkg::snf_lanes_t mode;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [2:0] bit_cnt;
    logic [3:0] out_q;
    logic dtr;
    logic rx_edge;
    logic tx_edge;
    logic cmd_done;
    logic [7:0] cmd_next;
    logic [2:0] nb;

    assign dtr = mode == snf_pkg::SNF_X4DTR;
    assign nb = lane_bits(mode);
    assign cmd_next = shift_in(rx_sh, lanes, snf_pkg::SNF_X1);
    assign cmd_done = state == snf_pkg::SNF_CMD && act && sclk_rise && bit_cnt == 3'h7;
    assign rx_edge = act && !drive_out && (sclk_rise || (dtr && sclk_fall));
    assign tx_edge = act && drive_out && (sclk_fall || (dtr && sclk_rise));

    // Interface state and command capture
    always_ff @(posedge sys_clk) begin
        if (srst || cs_rise) begin
            state <= snf_pkg::SNF_IDLE;
            mode <= snf_pkg::SNF_X1;
            bit_cnt <= 3'h0;
            rx_sh <= 8'h00;
        end else if (cs_fall) begin
            state <= snf_pkg::SNF_CMD;
            mode <= snf_pkg::SNF_X1;
            bit_cnt <= 3'h0;
        end else if (state == snf_pkg::SNF_CMD && act && sclk_rise) begin
            rx_sh <= cmd_next;
            bit_cnt <= bit_cnt + 3'h1;
            if (cmd_done) begin
                mode <= decode(cmd_next);
                if (decode(cmd_next) != snf_pkg::SNF_X1 &&
                    decode(cmd_next) != snf_pkg::SNF_X2 && !four_lane_enable) begin
                    state <= snf_pkg::SNF_REJECT;
                end else begin
                    state <= snf_pkg::SNF_DATA;
                end
            end
        end else if (state == snf_pkg::SNF_DATA && (rx_edge || tx_edge)) begin
            bit_cnt <= bit_cnt + nb;
            if (rx_edge) begin
                rx_sh <= shift_in(rx_sh, lanes, mode);
            end
        end
    end

    // Command and received byte
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmd <= 8'h00;
            rx_data <= 8'h00;
        end else if (cmd_done) begin
            cmd <= cmd_next;
        end else if (state == snf_pkg::SNF_DATA && rx_edge && bit_cnt + nb == 4'h8) begin
            rx_data <= shift_in(rx_sh, lanes, mode);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || cs_fall) begin
            tx_sh <= 8'h00;
            out_q <= 4'h0;
        end else if (state == snf_pkg::SNF_DATA && tx_edge) begin
            if (bit_cnt == 3'h0) begin
                tx_sh <= tx_data << nb;
                out_q <= mode == snf_pkg::SNF_X1 ? {2'b00, tx_data[7], 1'b0}
                       : mode == snf_pkg::SNF_X2 ? {2'b00, tx_data[7:6]}
                       : tx_data[7:4];
            end else begin
                tx_sh <= tx_sh << nb;
                out_q <= mode == snf_pkg::SNF_X1 ? {2'b00, tx_sh[7], 1'b0}
                       : mode == snf_pkg::SNF_X2 ? {2'b00, tx_sh[7:6]}
                       : tx_sh[7:4];
            end
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_cmd <= 1'b0;
            st_rxrdy <= 1'b0;
            st_rej <= 1'b0;
            st_txld <= 1'b0;
        end else begin
            st_cmd <= cmd_done || (st_cmd && !(clr_stat && reg_wdata[`SNF_SB_CMD]));
            st_rxrdy <= (state == snf_pkg::SNF_DATA && rx_edge && bit_cnt + nb == 4'h8) ||
                        (st_rxrdy && !(clr_stat && reg_wdata[`SNF_SB_RXRDY]));
            st_rej <= (cmd_done && state != snf_pkg::SNF_IDLE &&
                       decode(cmd_next) >= snf_pkg::SNF_X4 && !four_lane_enable) ||
                      (st_rej && !(clr_stat && reg_wdata[`SNF_SB_REJ]));
            st_txld <= (state == snf_pkg::SNF_DATA && tx_edge && bit_cnt == 3'h0) ||
                       (st_txld && !(clr_stat && reg_wdata[`SNF_SB_TXLD]));
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************

    logic drive;

    assign drive = act && drive_out && state == snf_pkg::SNF_DATA;
    assign serial_out_lane_one_oe = drive;
    assign serial_input_lane_zero_oe = drive && mode != snf_pkg::SNF_X1;
    assign lock_pin_n_oe = drive && mode >= snf_pkg::SNF_X4;
    assign pause_n_oe = drive && mode >= snf_pkg::SNF_X4;
    assign serial_input_lane_zero_o = out_q[0];
    assign serial_out_lane_one_o = out_q[1];
    assign lock_pin_n_o = out_q[2];
    assign pause_n_o = out_q[3];

    // ****************************************
    // Register read
    // ****************************************

    // Read data one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (srst || !reg_re) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                `SNF_OFS_FEAT: reg_rdata <= feat;
                `SNF_OFS_CTRL: reg_rdata <= {7'h00, drive_out};
                `SNF_OFS_TX: reg_rdata <= tx_data;
                `SNF_OFS_RX: reg_rdata <= rx_data;
                `SNF_OFS_STAT: reg_rdata <= {mode, st_txld, st_rej, st_rxrdy, st_cmd,
                                             paused, selected};
                `SNF_OFS_CMD: reg_rdata <= cmd;
                `SNF_OFS_COL_LO: reg_rdata <= column_offset[7:0];
                `SNF_OFS_COL_HI: reg_rdata <= {4'h0, column_offset[11:8]};
                `SNF_OFS_ROW0: reg_rdata <= row_index[7:0];
                `SNF_OFS_ROW1: reg_rdata <= row_index[15:8];
                `SNF_OFS_ROW2: reg_rdata <= {6'h00, row_index[17:16]};
                `SNF_OFS_MAP: reg_rdata <= {4'h0, in_spare, prog_ok, read_ok, col_in_bounds};
                `SNF_OFS_PAGE: reg_rdata <= {2'b00, page};
                `SNF_OFS_BLK_LO: reg_rdata <= block[7:0];
                `SNF_OFS_BLK_HI: reg_rdata <= {4'h0, block[11:8]};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************

    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence quad_refused_s;
        state == snf_pkg::SNF_CMD && cmd_done && !four_lane_enable &&
        decode(cmd_next) >= snf_pkg::SNF_X4;
    endsequence

    sequence deselect_s;
        cs_rise;
    endsequence

    pause_float_a: assert property (paused |-> !(serial_out_lane_one_oe ||
        serial_input_lane_zero_oe || lock_pin_n_oe || pause_n_oe))
        else $error("pin driven while paused");
    quad_reject_a: assert property (quad_refused_s |=> state == snf_pkg::SNF_REJECT)
        else $error("four-lane command taken without enable");
    fall_drive_a: assert property ($changed(out_q) && !dtr && !$past(cs_fall) |->
        $past(sclk_fall))
        else $error("output changed off a falling edge");
    cs_idle_a: assert property (deselect_s |=> state == snf_pkg::SNF_IDLE ##1
        state != snf_pkg::SNF_DATA)
        else $error("deselect did not end command");
    pause_reset_a: assert property (paused && cs_rise |=> !paused)
        else $error("pause survived deselect");
    qe_nopause_a: assert property (four_lane_enable |=> !paused)
        else $error("pause active with four lanes");
    quad_lanes_a: assert property (pause_n_oe |-> mode >= snf_pkg::SNF_X4)
        else $error("lane three driven outside four-lane mode");
    lock_hold_a: assert property (wr_feat && lock_act |=>
        $stable(feat[`SNF_FB_PROT_HI:`SNF_FB_PROT_LO]))
        else $error("protect bits changed under lock");
    pause_edge_a: assert property ($rose(paused) |-> !$past(sclk_lvl) && !$past(pause_lvl))
        else $error("pause entered with clock high");
    spare_prog_a: assert property (feat[`SNF_FB_ECC] && column_offset > `SNF_SPARE_PROG_LAST
        |-> !prog_ok)
        else $error("spare tail programmable with ECC on");

endmodule

/* File: test/snf_host_model.sv */
// Host serial controller model: link clock, select and lane zero.
// Assumes mode 0 timing and a 200 ns link clock period.
`timescale 1ns/1ps

module snf_host_model (
    output logic sclk,
    output logic chip_select_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b0;
    end

    // Select changes only with the clock still
    task automatic select(input logic en);
        #107;
        chip_select_n = ~en;
        #100;
    endtask

    // Drive on falling edge, capture just before the next falling edge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        #7;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #100;
            sclk = 1'b1;
            #100;
            // Late capture: device output lags its falling edge
            rx[i] = miso;
            sclk = 1'b0;
        end
        mosi = ~mosi; // Stale bit is not left on the line
    endtask
endmodule

/* File: test/tb_top.sv */
// Testbench of the serial NAND front end: map, lock, commands, pause.
// Assumes snf_host_model plays the host on the link side.
`timescale 1ns/1ps
`include "snf_cfg.svh"

module tb_top;
    typedef struct packed {
        logic [7:0] feat;
        logic [11:0] col;
        logic [17:0] row;
        logic [3:0] map;
        logic [5:0] page;
        logic [11:0] blk;
    } snf_row_t;
    logic sys_clk, srst, reg_we, reg_re, sclk, cs_n, mosi, lock_n, pause_n;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rx;
    logic o0, e0, o1, e1, o2, e2, o3, e3;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    snf_row_t rows [5] = '{'{8'h04, 12'h83F, 18'h3FFC5, 4'hF, 6'h05, 12'hFFF},
        '{8'h04, 12'h840, 18'h00040, 4'hA, 6'h00, 12'h001},
        '{8'h00, 12'h87F, 18'h0003F, 4'hF, 6'h3F, 12'h000},
        '{8'h00, 12'h880, 18'h20000, 4'h0, 6'h00, 12'h800},
        '{8'h04, 12'h7FF, 18'h00001, 4'h7, 6'h01, 12'h000}};
    // Wires resolved from every driver
    wire l0 = e0 ? o0 : mosi;
    wire l1 = e1 ? o1 : 1'bz;
    wire l2 = e2 ? o2 : lock_n;
    wire l3 = e3 ? o3 : pause_n;

    snf_front dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .sclk(sclk),
        .chip_select_n(cs_n), .serial_input_lane_zero_i(l0), .serial_input_lane_zero_o(o0),
        .serial_input_lane_zero_oe(e0), .serial_out_lane_one_i(l1),
        .serial_out_lane_one_o(o1), .serial_out_lane_one_oe(e1), .lock_pin_n_i(l2),
        .lock_pin_n_o(o2), .lock_pin_n_oe(e2), .pause_n_i(l3), .pause_n_o(o3),
        .pause_n_oe(e3));
    snf_host_model host (.sclk(sclk), .chip_select_n(cs_n), .mosi(mosi), .miso(l1));

    // Clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge sys_clk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        @(negedge sys_clk);
        check(reg_rdata & m, exp);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        srst <= 1'b1;
        reg_we <= 1'b0;
        reg_re <= 1'b0;
        reg_addr <= 4'h0;
        reg_wdata <= 8'h00;
        // lock and pause held high until their tests
        lock_n <= 1'b1;
        pause_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(`SNF_OFS_FEAT, `SNF_FEAT_RST);
        rd(4'hF, 8'h00);
        foreach (rows[i]) begin
            wr(`SNF_OFS_FEAT, rows[i].feat);
            wr(`SNF_OFS_COL_LO, rows[i].col[7:0]);
            wr(`SNF_OFS_COL_HI, {4'h0, rows[i].col[11:8]});
            wr(`SNF_OFS_ROW0, rows[i].row[7:0]);
            wr(`SNF_OFS_ROW1, rows[i].row[15:8]);
            wr(`SNF_OFS_ROW2, {6'h00, rows[i].row[17:16]});
            rd(`SNF_OFS_MAP, {4'h0, rows[i].map});
            rd(`SNF_OFS_PAGE, {2'h0, rows[i].page});
            rd(`SNF_OFS_BLK_LO, rows[i].blk[7:0]);
            rd(`SNF_OFS_BLK_HI, {4'h0, rows[i].blk[11:8]});
        end
        lock_n <= 1'b0;
        wr(`SNF_OFS_FEAT, 8'h06);
        repeat (6) @(posedge sys_clk);
        wr(`SNF_OFS_FEAT, 8'hFE);
        rd(`SNF_OFS_FEAT, 8'h06);
        wr(`SNF_OFS_FEAT, 8'h07);
        wr(`SNF_OFS_FEAT, 8'hFF);
        rd(`SNF_OFS_FEAT, 8'hFF);
        wr(`SNF_OFS_FEAT, 8'h05);
        lock_n <= 1'b1;
        pause_n <= 1'b0;
        host.select(1'b1);
        host.xfer(8'h6B, rx);
        rd(`SNF_OFS_CMD, 8'h6B);
        rd(`SNF_OFS_STAT, 8'h00, 8'h12);
        pause_n <= 1'b1;
        host.select(1'b0);
        wr(`SNF_OFS_FEAT, 8'h04);
        wr(`SNF_OFS_STAT, 8'hFF);
        host.select(1'b1);
        host.xfer(8'h6B, rx);
        rd(`SNF_OFS_STAT, 8'h10, 8'h10);
        host.select(1'b0);
        wr(`SNF_OFS_STAT, 8'hFF);
        wr(`SNF_OFS_CTRL, 8'h01);
        wr(`SNF_OFS_TX, 8'hA5);
        host.select(1'b1);
        host.xfer(8'h03, rx);
        rd(`SNF_OFS_STAT, 8'h05, 8'h15);
        rd(`SNF_OFS_CMD, 8'h03);
        host.xfer(8'h00, rx);
        check(rx, 8'hA5);
        host.select(1'b0);
        rd(`SNF_OFS_STAT, 8'h00, 8'h01);
        wr(`SNF_OFS_STAT, 8'hFF);
        host.select(1'b1);
        pause_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(`SNF_OFS_STAT, 8'h02, 8'h02);
        host.xfer(8'hFF, rx);
        pause_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        host.xfer(8'h9F, rx);
        rd(`SNF_OFS_CMD, 8'h9F);
        pause_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        host.select(1'b0);
        rd(`SNF_OFS_STAT, 8'h00, 8'h03);
        pause_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        wr(`SNF_OFS_CTRL, 8'h00);
        host.select(1'b1);
        host.xfer(8'h13, rx);
        rd(`SNF_OFS_CMD, 8'h13);
        host.xfer(8'h5A, rx);
        rd(`SNF_OFS_RX, 8'h5A);
        rd(`SNF_OFS_STAT, 8'h08, 8'h08);
        host.select(1'b0);
        give_verdict();
    end
endmodule
